// ### inc/sbw_pkg.sv
package sbw_pkg;
   localparam logic [7:0] ADDR_WRITE = 8'hD4;
   localparam int NUM_REGS = 16;
   localparam int IDX_W = 4;
   localparam int CLK_HZ = 10000000;
   localparam int LINK_BPS = 100000;
   // Shortest link clock half period in system cycles, rounded down.
   localparam int HALF_BIT_CYC = CLK_HZ / LINK_BPS / 2;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] REG6_RESET = 8'hFF;
   localparam logic [IDX_W-1:0] REG6_IDX = 4'h6;
   localparam logic [7:0] REG10_RESET = 8'h01;
   localparam logic [IDX_W-1:0] REG10_IDX = 4'hA;

   typedef enum logic [1:0] {
      SBW_ADDR,
      SBW_INDEX,
      SBW_COUNT,
      SBW_DATA
   } sbw_phase_e;

   typedef struct packed {
      logic start;
      logic stop;
      logic bit_rise;
      logic bit_fall;
      logic sda;
   } sbw_line_s;

   typedef struct packed {
      logic valid;
      logic [IDX_W-1:0] idx;
      logic [7:0] data;
   } sbw_wr_s;
endpackage

// ### rtl/sbw_line_sense.sv
`timescale 1ns/10ps
module sbw_line_sense (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output sbw_pkg::sbw_line_s ev_o
);
   import sbw_pkg::*;

   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_q;
   logic sda_q;

   // Three flops per pin; the second and third stages feed the edge detect.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_i};
         sda_sync <= {sda_sync[0], sda_i};
         scl_q <= scl_sync[1];
         sda_q <= sda_sync[1];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ev_o <= '0;
      end else begin
         ev_o.start <= scl_sync[1] && scl_q && sda_q && !sda_sync[1];
         ev_o.stop <= scl_sync[1] && scl_q && !sda_q && sda_sync[1];
         ev_o.bit_rise <= scl_sync[1] && !scl_q;
         ev_o.bit_fall <= !scl_sync[1] && scl_q;
         ev_o.sda <= sda_sync[1];
      end
   end
endmodule

// ### rtl/sbw_target.sv
`timescale 1ns/10ps
// Overview of operation
// - Address byte D4 selects write; device acknowledges it.
// - Index byte N is acknowledged and becomes first write location.
// - Byte count X is acknowledged.
// - Each data byte is acknowledged, stored, and location advances.
// - Link runs at 100 kbit/s or slower.
// - Data keeps loading sequentially until a start or stop arrives.
// - Reset loads every configuration register with its default.
module sbw_target (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic [sbw_pkg::NUM_REGS*8-1:0] cfg_o,
   output logic [7:0] byte_count_o,
   output sbw_pkg::sbw_wr_s wr_o,
   output logic busy_o
);
   import sbw_pkg::*;

   sbw_line_s ev;
   sbw_phase_e phase;
   logic active;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic ack_slot;
   logic ack_drive;
   logic [IDX_W-1:0] loc;
   logic [7:0] regs [NUM_REGS];
   logic [7:0] next_byte;
   logic frame_edge;
   logic take_bit;
   logic byte_end;
   logic addr_match;

   sbw_line_sense u_sense (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .ev_o(ev)
   );

   // Bits are taken on the synchronised rising edge of the link clock.
   // The edge detect needs a few system cycles per link half period; at
   // 100 kbit/s there are HALF_BIT_CYC of them, far more than it uses.
   assign next_byte = {shift[6:0], ev.sda};

   // A start or stop anywhere drops the byte in progress.
   assign frame_edge = ev.start || ev.stop;
   assign take_bit = active && ev.bit_rise && !ack_slot;
   // The falling edge after the eighth bit opens the acknowledge slot.
   assign byte_end = active && ev.bit_fall && (bit_cnt == 4'h8);
   assign addr_match = (shift == ADDR_WRITE);

   // Serial shift register, most significant bit first.
   always_ff @(posedge clk_i) begin
      if (srst_i || frame_edge) begin
         shift <= 8'h00;
      end else if (take_bit) begin
         shift <= next_byte;
      end
   end

   // Bit counter: eight data bits, then cleared for the acknowledge slot.
   always_ff @(posedge clk_i) begin
      if (srst_i || frame_edge) begin
         bit_cnt <= 4'h0;
      end else if (take_bit) begin
         bit_cnt <= bit_cnt + 4'h1;
      end else if (byte_end) begin
         bit_cnt <= 4'h0;
      end
   end

   // The ninth clock of each byte carries no data and is not shifted in.
   always_ff @(posedge clk_i) begin
      if (srst_i || frame_edge) begin
         ack_slot <= 1'b0;
      end else if (byte_end) begin
         ack_slot <= 1'b1;
      end else if (ev.bit_fall && ack_slot) begin
         ack_slot <= 1'b0;
      end
   end

   // A foreign address drops out until the next start.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         active <= 1'b0;
      end else if (ev.start) begin
         active <= 1'b1;
      end else if (ev.stop) begin
         active <= 1'b0;
      end else if (byte_end && phase == SBW_ADDR && !addr_match) begin
         active <= 1'b0;
      end
   end

   // Transaction phase; any start or stop reopens addressing.
   always_ff @(posedge clk_i) begin
      if (srst_i || frame_edge) begin
         phase <= SBW_ADDR;
      end else if (byte_end) begin
         case (phase)
            SBW_ADDR: begin
               if (addr_match) begin
                  phase <= SBW_INDEX;
               end
            end
            SBW_INDEX: begin
               phase <= SBW_COUNT;
            end
            SBW_COUNT: begin
               phase <= SBW_DATA;
            end
            SBW_DATA: begin
               phase <= SBW_DATA;
            end
            default: begin
               phase <= SBW_ADDR;
            end
         endcase
      end
   end

   // The acknowledge stands from the slot's opening until the next falling
   // edge of the link clock, so the host sees it through the whole high
   // phase of the ninth clock.
   always_ff @(posedge clk_i) begin
      if (srst_i || frame_edge) begin
         ack_drive <= 1'b0;
      end else if (byte_end) begin
         ack_drive <= (phase != SBW_ADDR) || addr_match;
      end else if (ev.bit_fall) begin
         ack_drive <= 1'b0;
      end
   end

   // The data pin is only ever pulled low; the pull-up makes the high.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sda_o <= 1'b1;
      end else begin
         sda_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sda_oe_o <= 1'b0;
      end else begin
         sda_oe_o <= ack_drive;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= active;
      end
   end

   // Location pointer; it wraps past the last register.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         loc <= '0;
      end else if (byte_end && phase == SBW_INDEX) begin
         loc <= shift[IDX_W-1:0];
      end else if (byte_end && phase == SBW_DATA) begin
         loc <= loc + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         byte_count_o <= 8'h00;
      end else if (byte_end && phase == SBW_COUNT) begin
         byte_count_o <= shift;
      end
   end

   // Write strobe: one cycle per data byte taken, with its location.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_o <= '0;
      end else if (byte_end && phase == SBW_DATA) begin
         wr_o.valid <= 1'b1;
         wr_o.idx <= loc;
         wr_o.data <= shift;
      end else begin
         wr_o.valid <= 1'b0;
      end
   end

   // Default contents of one configuration register.
   function automatic logic [7:0] reset_value(input int k);
      logic [7:0] v;
      v = REG_RESET;
      if (IDX_W'(k) == REG6_IDX) begin
         v = REG6_RESET;
      end else if (IDX_W'(k) == REG10_IDX) begin
         v = REG10_RESET;
      end
      return v;
   endfunction

   // Storage and its output copy both leave reset holding the defaults,
   // then the outputs follow the registers one system cycle later.
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            regs[g] <= reset_value(g);
         end else if (wr_o.valid && wr_o.idx == IDX_W'(g)) begin
            regs[g] <= wr_o.data;
         end
      end
      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            cfg_o[g*8 +: 8] <= reset_value(g);
         end else begin
            cfg_o[g*8 +: 8] <= regs[g];
         end
      end
   end
endmodule

// ### tb/sbw_target_assertions.sv
`timescale 1ns/10ps
module sbw_target_assertions (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [sbw_pkg::NUM_REGS*8-1:0] cfg_o,
   input wire logic [7:0] byte_count_o,
   input wire sbw_pkg::sbw_wr_s wr_o,
   input wire logic busy_o
);
   import sbw_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic have_prev;
   logic [IDX_W-1:0] prev_idx;
   always_ff @(posedge clk_i) begin
      if (srst_i || !busy_o) begin
         have_prev <= 1'b0;
      end else if (wr_o.valid) begin
         have_prev <= 1'b1;
         prev_idx <= wr_o.idx;
      end
   end
   a_ack_pulls_low: assert property (sda_oe_o |-> !sda_o)
      else $error("ack not low");
   a_ack_rise_low: assert property ($rose(sda_oe_o) |-> !scl_i)
      else $error("ack rose in high");
   a_ack_fall_low: assert property ($fell(sda_oe_o) |-> !scl_i)
      else $error("ack fell in high");
   a_store_one: assert property (wr_o.valid |=> !wr_o.valid)
      else $error("store pulse long");
   a_store_lands: assert property (wr_o.valid |-> ##3
      cfg_o[8*$past(wr_o.idx,3) +: 8] == $past(wr_o.data,3))
      else $error("byte not stored");
   a_index_step: assert property (wr_o.valid && have_prev |->
      wr_o.idx == prev_idx + 1'b1) else $error("index skipped");
   a_reset_defaults: assert property ($fell(srst_i) |->
      cfg_o[55:48] == REG6_RESET && cfg_o[87:80] == REG10_RESET)
      else $error("bad default");
   a_store_busy: assert property (wr_o.valid |-> busy_o)
      else $error("store while idle");
endmodule
bind sbw_target sbw_target_assertions sbw_target_assertions_inst (
   .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .cfg_o(cfg_o),
   .byte_count_o(byte_count_o), .wr_o(wr_o), .busy_o(busy_o));

// ### tb/sbw_host_model.sv
`timescale 1ns/10ps
module sbw_host_model (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Data moves two cycles into the low phase so the target sees the
   // clock fall before the data change and never mistakes it for a stop.
   task automatic put_bit(input logic b, output logic s);
      step(2);
      sda_o = b;
      step(4);
      scl_o = 1'b1;
      step(2);
      s = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic open_frame();
      step(2);
      sda_o = 1'b0;
      step(2);
      scl_o = 1'b0;
   endtask
   task automatic close_frame();
      step(2);
      sda_o = 1'b0;
      step(4);
      scl_o = 1'b1;
      step(2);
      sda_o = 1'b1;
      step(12);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], s);
      end
      put_bit(1'b1, s);
      ack = !s;
   endtask
endmodule

// ### tb/tb_sbw_target.sv
`timescale 1ns/10ps
module tb_sbw_target;
   import sbw_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic scl, host_sda, sda_o, sda_oe_o, busy_o, sda_w, a;
   logic [NUM_REGS*8-1:0] cfg_o;
   logic [7:0] byte_count_o;
   sbw_wr_s wr_o;
   int num_errors = 0;
   int n_compared = 0;
   // The data line has a pull-up: it is low only while someone pulls it.
   assign sda_w = host_sda & !(sda_oe_o & !sda_o);
   sbw_target sbw_target_inst (.clk_i(clk_i), .srst_i(srst_i),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .cfg_o(cfg_o), .byte_count_o(byte_count_o), .wr_o(wr_o),
      .busy_o(busy_o));
   sbw_host_model h (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
      .sda_o(host_sda));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task chk(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[FAIL] %0t ns: %s", $time, msg);
      end
   endtask
   task print_verdict;
      $display("errors %0d of %0d compared", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task t_reset;
      chk(busy_o === 1'b0 && sda_oe_o === 1'b0, "busy after reset");
      for (int k = 0; k < NUM_REGS; k++) begin
         chk(cfg_o[8*k +: 8] === (k == 6 ? REG6_RESET :
            k == 10 ? REG10_RESET : REG_RESET), "bad default");
      end
   endtask
   task t_block;
      h.open_frame();
      h.put_byte(ADDR_WRITE, a);
      chk(a === 1'b1, "address not acked");
      h.put_byte(8'h0E, a);
      chk(a === 1'b1, "index not acked");
      h.put_byte(8'h04, a);
      chk(a === 1'b1, "count not acked");
      for (int i = 0; i < 4; i++) begin
         h.put_byte(8'hA0 + 8'(i), a);
         chk(a === 1'b1, "data not acked");
      end
      h.close_frame();
      chk(byte_count_o === 8'h04, "count not kept");
      chk(busy_o === 1'b0, "busy after stop");
      for (int i = 0; i < 4; i++) begin
         chk(cfg_o[8*((14 + i) % NUM_REGS) +: 8] === 8'hA0 + 8'(i),
            "data not stored");
      end
   endtask
   task t_foreign;
      h.open_frame();
      h.put_byte(8'hD6, a);
      chk(a === 1'b0, "foreign address acked");
      h.put_byte(8'h02, a);
      chk(a === 1'b0, "index acked after foreign");
      h.put_byte(8'h01, a);
      chk(a === 1'b0, "count acked after foreign");
      h.put_byte(8'h77, a);
      chk(a === 1'b0, "data acked after foreign");
      h.close_frame();
      chk(cfg_o[23:16] === REG_RESET, "foreign write landed");
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      #1 srst_i = 1'b0;
      t_reset();
      t_block();
      t_foreign();
      print_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      num_errors++;
      print_verdict();
   end
endmodule
